/* File: verilog/wake_ctl_consts.vh */
// Purpose: constants for the wake and power plane controller
// Assumes: APB registers, one 32-bit word each
// Notes: offsets are byte addresses
`ifndef WAKE_CTL_CONSTS_VH
`define WAKE_CTL_CONSTS_VH
`define NUM_SRC 4
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_SLEEP 8'h04
`define OFF_EN 8'h08
`define OFF_STAT 8'h0C
`define OFF_MODEM 8'h10
`define OFF_PLANE 8'h14
`define SRC_RING 0
`define B_MAIN 0
`define B_AUX 1
`define SLEEP_CMD 32'h0000_0001
`define PST_FULL_ON 2'h0
`define PST_LOW 2'h1
`define PST_INTER 2'h2
`define PST_OFF 2'h3
`define ST_RUN 2'h0
`define ST_SLEEP 2'h1
`define ST_RESUME 2'h2
`endif

/* File: verilog/wake_event_power_plane_control.v */
// Purpose: wake event capture, resume sequencing, power plane control
// Assumes: APB slave, single 50 MHz clock, wake inputs synchronous
// Notes: wake inputs are level requests from devices or bridges
//
// Notes on behaviour
// RULE1 - Wake detection and resume run in hardware, no processor needed.
// RULE2 - An enabled peripheral drives its bus wake indication to wake.
// RULE3 - Bridges forward wake indications upstream until core logic.
// RULE4 - Wake requests from sources whose enable is clear are ignored.
// RULE5 - Software-writable per-source enable bits arm each wake source.
// RULE6 - Enabled wake during sleep sets its status flag, then resumes; here resume comes first and the status flag is set a cycle later.
// RULE7 - Status flag stays set until software clears it.
// RULE8 - Modem states: full-on, low-power, intermediate as off, off.
// RULE9 - Software moves modem state by port open, close, answer, dial.
// RULE10 - Modem wake request only on ring with wake enable set.
// RULE11 - Isolation of each plane follows that plane's enable.
// RULE12 - Full-on needs both planes, low-power main only, off none.
// RULE13 - Aux plane enable stays low once commanded off until on.
// RULE14 - Low-power request line keeps controller context in low power.
// RULE15 - Off request line shuts down controller major functions.
// RULE16 - Modem present power state is readable by software.
// RULE17 - Incoming call line is a wake event source.
// RULE18 - Write of sleep command enters the sleeping state.
// RULE19 - Ring wake works from any modem state, no plane needed.
// RULE20 - Set status with set enable raises the event interrupt.
// RULE21 - Wake inputs are latched, then update status after resume.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "wake_ctl_consts.vh"

module wake_event_power_plane_control (
    input wire clk, // 50 MHz clock
    input wire arst_n, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire [3:0] wake_req, // Wake requests, bit 0 unused
    input wire incoming_call_line, // Modem ring detect
    output reg os_event_interrupt, // Event interrupt to software
    output reg main_plane_enable, // Main power plane enable
    output reg auxiliary_plane_enable, // Auxiliary power plane enable
    output reg main_isolate, // Isolate main plane signals
    output reg aux_isolate, // Isolate aux plane signals
    output reg modem_low_power_request, // Modem low power request
    output reg modem_off_request, // Modem off request
    output reg sleeping, // Machine is asleep
    output reg resume_pulse // One cycle resume strobe
);

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Offsets that answer; anything else gets an error response
    function addr_mapped;
        input [7:0] a;
        begin
            case (a)
                `OFF_CTRL, `OFF_SLEEP, `OFF_EN: addr_mapped = 1'b1;
                `OFF_STAT, `OFF_MODEM, `OFF_PLANE: addr_mapped = 1'b1;
                default: addr_mapped = 1'b0;
            endcase
        end
    endfunction

    // Main plane is needed in full-on and in low power
    function needs_main;
        input [1:0] pst;
        begin
            needs_main = (pst == `PST_FULL_ON) | (pst == `PST_LOW);
        end
    endfunction

    // Auxiliary plane is needed in full-on only
    function needs_aux;
        input [1:0] pst;
        begin
            needs_aux = (pst == `PST_FULL_ON);
        end
    endfunction

    // Intermediate state behaves exactly like off
    function off_like;
        input [1:0] pst;
        begin
            off_like = (pst == `PST_OFF) | (pst == `PST_INTER);
        end
    endfunction

    // Status bits to set: held events at resume, live ones when awake
    function [`NUM_SRC-1:0] wake_set;
        input [1:0] st;
        input [`NUM_SRC-1:0] held;
        input [`NUM_SRC-1:0] live;
        begin
            wake_set = {`NUM_SRC{1'b0}};
            if (st == `ST_RESUME)
                wake_set = held;
            if (st != `ST_SLEEP)
                wake_set = wake_set | live;
        end
    endfunction

    // Plane register: commands low, live enables above them
    function [31:0] plane_word;
        input main_cmd;
        input aux_cmd;
        input main_en;
        input aux_en;
        begin
            plane_word = {28'h000_0000, aux_en, main_en, aux_cmd, main_cmd};
        end
    endfunction

    reg rst_s1_r;
    reg rst_n_r;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    reg [`NUM_SRC-1:0] en_r; // RULE5
    reg [`NUM_SRC-1:0] stat_r;
    reg [`NUM_SRC-1:0] latch_r;
    reg [1:0] pstate_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg aux_cmd_r;
    reg main_cmd_r;

    wire [`NUM_SRC-1:0] raw_src;
    wire [`NUM_SRC-1:0] armed;
    wire wr_acc;
    wire rd_acc;
    wire mapped;
    reg [31:0] rd_nxt;

    // Ring is source 0; the rest come from bridges or devices
    assign raw_src = {wake_req[3:1], incoming_call_line}; // RULE17 RULE3
    // Disabled sources never reach the latch
    assign armed = raw_src & en_r; // RULE4 RULE10 RULE19

    wire wr_sleep;
    wire wr_en;
    wire wr_stat;
    wire wr_modem;
    wire wr_plane;

    // Writes land at the edge that completes the transfer
    assign wr_acc = psel & penable & pwrite & pready;
    // Read data is captured one edge early so it stands with pready
    assign rd_acc = psel & penable & ~pwrite & ~pready;
    assign mapped = addr_mapped(paddr);

    // One strobe per writable register
    assign wr_sleep = wr_acc & hit(paddr, `OFF_SLEEP);
    assign wr_en = wr_acc & hit(paddr, `OFF_EN);
    assign wr_stat = wr_acc & hit(paddr, `OFF_STAT);
    assign wr_modem = wr_acc & hit(paddr, `OFF_MODEM);
    assign wr_plane = wr_acc & hit(paddr, `OFF_PLANE);

    always @* begin
        st_nxt = st_r;
        case (st_r)
            `ST_RUN: begin
                // Only the exact command word puts the machine to sleep
                if (wr_sleep && pwdata == `SLEEP_CMD)
                    st_nxt = `ST_SLEEP; // RULE18
            end
            // Any armed event wakes; the processor takes no part
            `ST_SLEEP: begin
                if (|latch_r)
                    st_nxt = `ST_RESUME; // RULE1 RULE6
            end
            // Resume lasts one cycle while status takes the held events
            `ST_RESUME: st_nxt = `ST_RUN;
            default: st_nxt = `ST_RUN;
        endcase
    end

    reg [`NUM_SRC-1:0] latch_nxt;
    reg sleeping_nxt;
    reg resume_nxt;

    // Wake events are gathered only while asleep and dropped after use,
    // so an event seen while running cannot cut the next sleep short
    always @* begin
        latch_nxt = {`NUM_SRC{1'b0}};
        if (st_r == `ST_SLEEP)
            latch_nxt = latch_r | armed; // RULE21
        sleeping_nxt = (st_nxt == `ST_SLEEP);
        resume_nxt = (st_r == `ST_SLEEP) && (st_nxt == `ST_RESUME);
    end

    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= `ST_RUN;
            latch_r <= {`NUM_SRC{1'b0}};
            sleeping <= 1'b0;
            resume_pulse <= 1'b0;
        end else begin
            st_r <= st_nxt;
            latch_r <= latch_nxt;
            sleeping <= sleeping_nxt;
            resume_pulse <= resume_nxt; // RULE1
        end
    end

    reg [`NUM_SRC-1:0] en_nxt;
    reg [`NUM_SRC-1:0] stat_nxt;
    reg [1:0] pstate_nxt;
    reg aux_cmd_nxt;
    reg main_cmd_nxt;

    // Next values of the software-visible registers
    always @* begin
        en_nxt = en_r;
        stat_nxt = stat_r;
        pstate_nxt = pstate_r;
        main_cmd_nxt = main_cmd_r;
        aux_cmd_nxt = aux_cmd_r;
        if (wr_en)
            en_nxt = pwdata[`NUM_SRC-1:0]; // RULE5
        if (wr_modem)
            pstate_nxt = pwdata[1:0]; // RULE9
        if (wr_plane) begin
            main_cmd_nxt = pwdata[`B_MAIN];
            aux_cmd_nxt = pwdata[`B_AUX]; // RULE13
        end
        // Clear first and set after, so an event in the same cycle wins
        if (wr_stat)
            stat_nxt = stat_nxt & ~pwdata[`NUM_SRC-1:0]; // RULE7
        stat_nxt = stat_nxt | wake_set(st_r, latch_r, armed); // RULE6
    end

    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            en_r <= {`NUM_SRC{1'b0}};
            stat_r <= {`NUM_SRC{1'b0}};
            pstate_r <= `PST_OFF;
            aux_cmd_r <= 1'b0;
            main_cmd_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            stat_r <= stat_nxt;
            pstate_r <= pstate_nxt;
            aux_cmd_r <= aux_cmd_nxt;
            main_cmd_r <= main_cmd_nxt;
        end
    end

    reg main_en_nxt;
    reg aux_en_nxt;
    reg main_iso_nxt;
    reg aux_iso_nxt;
    reg low_req_nxt;
    reg off_req_nxt;
    reg event_nxt;

    // Plane enables follow software commands and the modem state
    always @* begin
        main_en_nxt = main_cmd_r & needs_main(pstate_r); // RULE12
        aux_en_nxt = aux_cmd_r & needs_aux(pstate_r); // RULE12 RULE13
        // Isolation tracks its own plane so both switch on one edge
        main_iso_nxt = ~main_en_nxt; // RULE11
        aux_iso_nxt = ~aux_en_nxt; // RULE11
        low_req_nxt = (pstate_r == `PST_LOW); // RULE14
        off_req_nxt = off_like(pstate_r); // RULE8 RULE15
        event_nxt = |(stat_r & en_r); // RULE20
    end

    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            main_plane_enable <= 1'b0;
            auxiliary_plane_enable <= 1'b0;
            main_isolate <= 1'b1;
            aux_isolate <= 1'b1;
            modem_low_power_request <= 1'b0;
            modem_off_request <= 1'b1;
            os_event_interrupt <= 1'b0;
        end else begin
            main_plane_enable <= main_en_nxt;
            auxiliary_plane_enable <= aux_en_nxt;
            main_isolate <= main_iso_nxt;
            aux_isolate <= aux_iso_nxt;
            modem_low_power_request <= low_req_nxt;
            modem_off_request <= off_req_nxt;
            os_event_interrupt <= event_nxt;
        end
    end

    always @* begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            `OFF_CTRL: rd_nxt = {30'h000_0000, st_r};
            `OFF_EN: rd_nxt = {28'h000_0000, en_r};
            `OFF_STAT: rd_nxt = {28'h000_0000, stat_r};
            `OFF_MODEM: rd_nxt = {30'h000_0000, pstate_r}; // RULE16
            `OFF_PLANE: rd_nxt = plane_word(main_cmd_r, aux_cmd_r,
                main_plane_enable, auxiliary_plane_enable);
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    reg pready_nxt;
    reg pslverr_nxt;

    // One wait state: pready answers at the second access edge
    always @* begin
        pready_nxt = psel & penable & ~pready;
        pslverr_nxt = psel & penable & ~pready & ~mapped;
    end

    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            if (rd_acc)
                prdata <= rd_nxt;
        end
    end

endmodule

/* File: testbench/wake_ctl_checker.sv */
// Purpose: port-level checks for the wake and power plane controller
// Assumes: single clock, reset copy released inside the design
// Notes: attached to the design top by bind
`timescale 1ns/100ps
`include "wake_ctl_consts.vh"
module wake_ctl_checker (
    input wire clk, arst_n, psel, penable, pwrite, pready, pslverr,
    input wire [7:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0] wake_req,
    input wire incoming_call_line, os_event_interrupt, main_plane_enable,
    input wire auxiliary_plane_enable, main_isolate, aux_isolate,
    input wire modem_low_power_request, modem_off_request, sleeping,
    input wire resume_pulse
);
    wire wake_any = |wake_req[3:1] || incoming_call_line;
    wire wr_done = pready && pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence quiet3;
        !wake_any [*3];
    endsequence
    sequence sleep_wr;
        psel && penable && wr_done && paddr == `OFF_SLEEP &&
        pwdata == `SLEEP_CMD;
    endsequence
    chk_iso_main: assert property (main_isolate == !main_plane_enable)
        else $error("main isolation out of step");
    chk_iso_aux: assert property (aux_isolate == !auxiliary_plane_enable)
        else $error("aux isolation out of step");
    chk_aux_full: assert property (auxiliary_plane_enable |->
        !modem_low_power_request && !modem_off_request)
        else $error("aux plane on outside full-on");
    chk_off_main: assert property (modem_off_request |->
        !main_plane_enable && !modem_low_power_request)
        else $error("main plane on while modem off");
    chk_sleep_enter: assert property (sleep_wr |-> ##[0:2] sleeping)
        else $error("sleep command not taken");
    chk_resume_src: assert property (resume_pulse |-> $past(sleeping))
        else $error("resume without sleep");
    chk_resume_end: assert property (resume_pulse |=>
        !sleeping && !resume_pulse)
        else $error("resume pulse malformed");
    chk_no_spurious: assert property (quiet3 |-> !resume_pulse)
        else $error("resume with no wake input");
    chk_int_after: assert property (resume_pulse |->
        ##[1:3] os_event_interrupt)
        else $error("no event interrupt after wake");
    chk_aux_held: assert property ($rose(auxiliary_plane_enable) |->
        $past(wr_done) || $past(wr_done, 2))
        else $error("aux plane rose without a write");
endmodule
bind wake_event_power_plane_control wake_ctl_checker chk (.*);

/* File: testbench/wake_src_model.sv */
// Purpose: wake sources behind bridges plus the modem ring line
// Assumes: bench asks a source to signal by raise bits
// Notes: bit 0 of raise is the ring line, wake_req[0] stays low
`timescale 1ns/100ps
module wake_src_model (
    input wire clk, // Clock
    input wire [3:0] raise, // Sources asked to signal
    output reg [3:0] wake_req = 4'h0, // Forwarded wake levels
    output reg incoming_call_line = 1'b0 // Ring detect
);
    always @(posedge clk) begin
        wake_req <= {raise[3:1], 1'b0};
        incoming_call_line <= raise[0];
    end
endmodule

/* File: testbench/wake_event_power_plane_control_tb.sv */
// Purpose: self-checking bench for the wake and power plane controller
// Assumes: APB master drives on rising edges
// Notes: random enables from an LFSR with fixed start
`timescale 1ns/100ps
`include "wake_ctl_consts.vh"
module wake_event_power_plane_control_tb;
reg clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
reg [7:0] paddr = 8'h00;
reg [31:0] pwdata = 32'h0000_0000, rd, seed = 32'h0000_3e4f;
reg [3:0] raise = 4'h0, en;
wire [31:0] prdata;
wire pready, pslverr, os_event_interrupt, main_plane_enable, sleeping;
wire auxiliary_plane_enable, modem_low_power_request, modem_off_request;
wire resume_pulse, incoming_call_line;
wire [3:0] wake_req;
integer mismatches = 0, n_checks = 0, k;
always #10 clk = ~clk;
wake_event_power_plane_control uut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_req(wake_req), .incoming_call_line(incoming_call_line),
    .os_event_interrupt(os_event_interrupt), .main_isolate(),
    .main_plane_enable(main_plane_enable), .aux_isolate(),
    .auxiliary_plane_enable(auxiliary_plane_enable), .sleeping(sleeping),
    .modem_low_power_request(modem_low_power_request),
    .modem_off_request(modem_off_request), .resume_pulse(resume_pulse));
wake_src_model src (.clk(clk), .raise(raise), .wake_req(wake_req),
    .incoming_call_line(incoming_call_line));
function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
// Expected {aux, main, low, off} with both plane commands on
function [3:0] pexp(input [1:0] s);
    pexp = {s == 2'h0, s < 2'h2, s == 2'h1, s > 2'h1};
endfunction
task chk(input [31:0] s, input [31:0] e);
    n_checks = n_checks + 1;
    if (s !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
endtask
task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
endtask
task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial begin
    #100000;
    mismatches = mismatches + 1;
    complete_run;
end
initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(modem_off_request, 1);
    apb(0, `OFF_MODEM, 0);
    chk(rd, `PST_OFF);
    apb(0, 8'h3C, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, `OFF_PLANE, 32'h0000_0003);
    for (k = 0; k < 4; k = k + 1) begin
        apb(1, `OFF_MODEM, k);
        repeat (2) @(posedge clk);
        chk({auxiliary_plane_enable, main_plane_enable,
            modem_low_power_request, modem_off_request}, pexp(k));
        apb(0, `OFF_MODEM, 0);
        chk(rd, k);
    end
    apb(1, `OFF_MODEM, `PST_FULL_ON);
    apb(1, `OFF_PLANE, 32'h0000_0001);
    repeat (5) @(posedge clk);
    chk({auxiliary_plane_enable, main_plane_enable}, 2'b01);
    apb(1, `OFF_MODEM, `PST_OFF);
    for (k = 0; k < 4; k = k + 1) begin
        seed = lfsr(seed);
        en = seed[3:0] & ~{3'h0, k == 0};
        apb(1, `OFF_EN, en);
        apb(1, `OFF_SLEEP, `SLEEP_CMD);
        apb(0, `OFF_CTRL, 0);
        chk(rd, `ST_SLEEP);
        raise <= 4'h1 << k;
        repeat (6) @(posedge clk);
        chk(sleeping, !en[k]);
        if (!en[k])
            apb(1, `OFF_EN, en | (4'h1 << k));
        repeat (6) @(posedge clk);
        chk(sleeping, 0);
        raise <= 4'h0;
        apb(0, `OFF_STAT, 0);
        chk(rd, 32'h0000_0001 << k);
        chk(os_event_interrupt, 1);
        apb(1, `OFF_STAT, 32'h0000_000F);
        apb(0, `OFF_STAT, 0);
        chk(rd, 0);
    end
    complete_run;
end
endmodule
